// ===== include/rssu_params.svh
`ifndef RSSU_PARAMS_SVH
`define RSSU_PARAMS_SVH

`define RSSU_ADDR_STATUS   12'h000
`define RSSU_BIT_TRAP      15
`define RSSU_BIT_ILLEGAL   14
`define RSSU_BIT_CFGMIS    9
`define RSSU_BIT_REGKEEP   8
`define RSSU_BIT_PIN       7
`define RSSU_BIT_SOFT      6
`define RSSU_BIT_WDEN      5
`define RSSU_BIT_WATCHDOG_TIMEOUT_FLAG      4
`define RSSU_BIT_SLEEP     3
`define RSSU_BIT_IDLE      2
`define RSSU_BIT_BROWN     1
`define RSSU_BIT_POR       0
`define RSSU_IMPL_MASK     16'hC3FF
`define RSSU_RESET_VALUE   16'h0003
`define RSSU_CYC_PER_INSTR 4

`endif

// ===== include/rssu_pkg.sv
package rssu_pkg;
  typedef logic [15:0] rssu_word_t;
endpackage

// ===== rtl/rssu_sync.sv
`timescale 1ns/1ps
module rssu_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] stage1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1 <= '0;
      dout   <= '0;
    end else begin
      stage1 <= din;
      dout   <= stage1;
    end
  end
endmodule

// ===== rtl/rssu_top.sv
`timescale 1ns/1ps
`include "rssu_params.svh"
module rssu_top
  import rssu_pkg::*;
#(
  parameter int INSTR_CYC = `RSSU_CYC_PER_INSTR
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Reset source levels
  input  wire logic        power_on_src,
  input  wire logic        brownout_src,
  input  wire logic        master_clear_pin_n,
  input  wire logic        config_mismatch_src,
  input  wire logic        trap_conflict_src,
  input  wire logic        illegal_cond_src,
  // Single-cycle events from core logic, then the low-power and fuse levels
  input  wire logic        soft_reset_req,
  input  wire logic        watchdog_timeout,
  input  wire logic        sleep_entered,
  input  wire logic        idle_entered,
  input  wire logic        in_low_power,
  input  wire logic        watchdog_fuse_enable,
  // Outputs
  output logic             system_reset_out,
  output logic             watchdog_run,
  output logic             regulator_sleep_keep,
  output logic             wake_request
);

  logic [5:0] src_sync;
  rssu_word_t status;
  rssu_word_t next_status;
  logic [2:0] soft_cnt;
  logic       soft_hold;

  // Pins and analog supervisors are asynchronous to pclk
  rssu_sync #(.WIDTH(6)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .din     ({power_on_src, brownout_src, ~master_clear_pin_n,
               config_mismatch_src, trap_conflict_src,
               illegal_cond_src}),
    .dout    (src_sync)
  );

  wire por_s   = src_sync[5];
  wire bor_s   = src_sync[4];
  wire pin_s   = src_sync[3];
  wire cfg_s   = src_sync[2];
  wire trap_s  = src_sync[1];
  wire ill_s   = src_sync[0];

  wire wdt_reset = watchdog_timeout & ~in_low_power;
  wire wdt_wake  = watchdog_timeout &  in_low_power;

  // Any synchronised level source holds reset on its own
  wire any_level = por_s | bor_s | pin_s | cfg_s | trap_s | ill_s;
  // Core requests that reset for a bounded time
  wire core_reset = soft_reset_req | soft_hold | wdt_reset;

  // APB decode
  wire hit      = (paddr[11:2] == 10'(`RSSU_ADDR_STATUS >> 2));
  wire acc      = psel & penable;
  wire wr_en    = acc & pwrite & hit & pstrb[0] & pstrb[1];
  wire [15:0] wr_val = pwdata[15:0] & `RSSU_IMPL_MASK;
  // Written control bits; outputs follow them through status one cycle later unless power-on is active; the fuse holds watchdog_run high
  wire wr_keep_bit = wr_val[`RSSU_BIT_REGKEEP];
  wire wr_wden_bit = wr_val[`RSSU_BIT_WDEN];

  // Hardware set terms
  rssu_word_t hw_set;
  always_comb begin
    hw_set = '0;
    hw_set[`RSSU_BIT_TRAP]    = trap_s;
    hw_set[`RSSU_BIT_ILLEGAL] = ill_s;
    hw_set[`RSSU_BIT_CFGMIS]  = cfg_s;
    hw_set[`RSSU_BIT_PIN]     = pin_s;
    hw_set[`RSSU_BIT_SOFT]    = soft_reset_req;
    hw_set[`RSSU_BIT_WATCHDOG_TIMEOUT_FLAG]    = watchdog_timeout;
    hw_set[`RSSU_BIT_SLEEP]   = sleep_entered;
    hw_set[`RSSU_BIT_IDLE]    = idle_entered;
    hw_set[`RSSU_BIT_BROWN]   = bor_s;
    hw_set[`RSSU_BIT_POR]     = por_s;
  end

  // Software write first, hardware set on top; power-on wipes others
  always_comb begin
    next_status = status;
    if (wr_en)
      next_status = wr_val;
    next_status = next_status | hw_set;
    if (por_s)
      next_status = `RSSU_RESET_VALUE & ~16'h0002 | 16'h0001;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      status <= `RSSU_RESET_VALUE;
    else
      status <= next_status;
  end

  // Software reset lasts one instruction cycle plus one pclk cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      soft_cnt  <= '0;
      soft_hold <= 1'b0;
    end else if (soft_reset_req) begin
      soft_cnt  <= 3'(INSTR_CYC - 1);
      soft_hold <= 1'b1;
    end else if (soft_cnt != 3'h0) begin
      soft_cnt  <= soft_cnt - 3'h1;
    end else begin
      soft_hold <= 1'b0;
    end
  end

  // Merged master reset; held as long as any source is active.
  // Watchdog reset lasts one cycle; unlike soft reset, the watchdog has no hold.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      system_reset_out <= 1'b1;
    else
      system_reset_out <= any_level | core_reset;
  end

  assign watchdog_run = status[`RSSU_BIT_WDEN] | watchdog_fuse_enable;
  assign regulator_sleep_keep = status[`RSSU_BIT_REGKEEP];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      wake_request <= 1'b0;
    else
      wake_request <= wdt_wake;
  end

  // Zero wait state; unmapped address returns error, data still reads status
  assign pready  = 1'b1;
  assign pslverr = acc & ~hit;
  assign prdata  = {16'h0000, status & `RSSU_IMPL_MASK};

  // Nothing asks for reset this cycle
  wire quiet = !any_level && !soft_reset_req && !watchdog_timeout;

  // Soft request that starts a fresh hold
  sequence s_soft;
    soft_reset_req && !soft_hold;
  endsequence

  // Soft request with no level source behind it
  sequence s_soft_alone;
    s_soft ##0 !any_level;
  endsequence

  // Counter plus output stage; five cycles at the default INSTR_CYC
  sequence s_quiet_hold;
    quiet [*5];
  endsequence

  property p_any_src;
    @(posedge pclk) disable iff (!presetn)
      any_level || soft_reset_req || wdt_reset |=> system_reset_out;
  endproperty
  a_any_src: assert property (p_any_src)
    else $error("reset source without system reset");

  property p_release;
    @(posedge pclk) disable iff (!presetn)
      !any_level && !core_reset |=> !system_reset_out;
  endproperty
  a_release: assert property (p_release)
    else $error("system reset held with no source");

  property p_flag_set;
    @(posedge pclk) disable iff (!presetn)
      !por_s |=> (status & $past(hw_set)) == $past(hw_set);
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("reset kind left its flag clear");

  property p_por_clear;
    @(posedge pclk) disable iff (!presetn)
      por_s |=> status == 16'h0001;
  endproperty
  a_por_clear: assert property (p_por_clear)
    else $error("power-on did not clear flags");

  property p_sw_write;
    @(posedge pclk) disable iff (!presetn)
      wr_en && hw_set == 16'h0000 && !por_s && !soft_hold
        |=> status == $past(wr_val) && !system_reset_out;
  endproperty
  a_sw_write: assert property (p_sw_write)
    else $error("software write wrong");

  property p_trap_set;
    @(posedge pclk) disable iff (!presetn)
      trap_s && !por_s |=> status[`RSSU_BIT_TRAP];
  endproperty
  a_trap_set: assert property (p_trap_set)
    else $error("trap flag not set");

  property p_trap_zero;
    @(posedge pclk) disable iff (!presetn)
      !trap_s && !status[`RSSU_BIT_TRAP]
        && !(wr_en && wr_val[`RSSU_BIT_TRAP]) |=> !status[`RSSU_BIT_TRAP];
  endproperty
  a_trap_zero: assert property (p_trap_zero)
    else $error("trap flag set without trap");

  property p_ill_set;
    @(posedge pclk) disable iff (!presetn)
      ill_s && !por_s |=> status[`RSSU_BIT_ILLEGAL];
  endproperty
  a_ill_set: assert property (p_ill_set)
    else $error("illegal condition flag not set");

  property p_unimpl;
    @(posedge pclk) disable iff (!presetn)
      prdata[31:16] == 16'h0000 && prdata[13:10] == 4'h0;
  endproperty
  a_unimpl: assert property (p_unimpl)
    else $error("unimplemented bits nonzero");

  property p_cfg_set;
    @(posedge pclk) disable iff (!presetn)
      cfg_s && !por_s |=> status[`RSSU_BIT_CFGMIS];
  endproperty
  a_cfg_set: assert property (p_cfg_set)
    else $error("configuration mismatch flag not set");

  property p_regkeep;
    @(posedge pclk) disable iff (!presetn)
      wr_en && !por_s |=> regulator_sleep_keep == $past(wr_keep_bit);
  endproperty
  a_regkeep: assert property (p_regkeep)
    else $error("regulator keep does not follow write");

  property p_pin_set;
    @(posedge pclk) disable iff (!presetn)
      pin_s && !por_s |=> status[`RSSU_BIT_PIN];
  endproperty
  a_pin_set: assert property (p_pin_set)
    else $error("pin reset flag not set");

  property p_soft_set;
    @(posedge pclk) disable iff (!presetn)
      soft_reset_req && !por_s |=> status[`RSSU_BIT_SOFT];
  endproperty
  a_soft_set: assert property (p_soft_set)
    else $error("soft reset flag not set");

  property p_wden;
    @(posedge pclk) disable iff (!presetn)
      watchdog_fuse_enable |-> watchdog_run;
  endproperty
  a_wden: assert property (p_wden)
    else $error("fuse did not force watchdog");

  property p_wden_sw;
    @(posedge pclk) disable iff (!presetn)
      wr_en && !por_s ##1 !watchdog_fuse_enable
        |-> watchdog_run == $past(wr_wden_bit);
  endproperty
  a_wden_sw: assert property (p_wden_sw)
    else $error("watchdog enable does not follow write");

  property p_watchdog_timeout_flag_set;
    @(posedge pclk) disable iff (!presetn)
      watchdog_timeout && !por_s |=> status[`RSSU_BIT_WATCHDOG_TIMEOUT_FLAG];
  endproperty
  a_watchdog_timeout_flag_set: assert property (p_watchdog_timeout_flag_set)
    else $error("watchdog time-out flag not set");

  property p_sleep_set;
    @(posedge pclk) disable iff (!presetn)
      sleep_entered && !por_s |=> status[`RSSU_BIT_SLEEP];
  endproperty
  a_sleep_set: assert property (p_sleep_set)
    else $error("sleep flag not set");

  property p_idle_set;
    @(posedge pclk) disable iff (!presetn)
      idle_entered && !por_s |=> status[`RSSU_BIT_IDLE];
  endproperty
  a_idle_set: assert property (p_idle_set)
    else $error("idle flag not set");

  property p_bor_set;
    @(posedge pclk) disable iff (!presetn)
      bor_s && !por_s |=> status[`RSSU_BIT_BROWN];
  endproperty
  a_bor_set: assert property (p_bor_set)
    else $error("brown-out flag not set");

  property p_soft_len;
    @(posedge pclk) disable iff (!presetn)
      s_soft_alone ##1 s_quiet_hold |=> !system_reset_out;
  endproperty
  a_soft_len: assert property (p_soft_len)
    else $error("soft reset not released");

  property p_soft_hold;
    @(posedge pclk) disable iff (!presetn)
      s_soft |=> system_reset_out [*5];
  endproperty
  a_soft_hold: assert property (p_soft_hold)
    else $error("soft reset released early");

  property p_wdt_sleep;
    @(posedge pclk) disable iff (!presetn)
      wdt_wake |=> wake_request;
  endproperty
  a_wdt_sleep: assert property (p_wdt_sleep)
    else $error("watchdog did not wake");

  property p_wdt_quiet;
    @(posedge pclk) disable iff (!presetn)
      !wdt_wake |=> !wake_request;
  endproperty
  a_wdt_quiet: assert property (p_wdt_quiet)
    else $error("wake without watchdog in low power");

  property p_wdt_no_rst;
    @(posedge pclk) disable iff (!presetn)
      wdt_wake && !any_level && !soft_reset_req && !soft_hold
        |=> !system_reset_out;
  endproperty
  a_wdt_no_rst: assert property (p_wdt_no_rst)
    else $error("watchdog in low power caused reset");

  property p_hw_wins;
    @(posedge pclk) disable iff (!presetn)
      wr_en && !pwdata[`RSSU_BIT_PIN] && pin_s && !por_s
        |=> status[`RSSU_BIT_PIN];
  endproperty
  a_hw_wins: assert property (p_hw_wins)
    else $error("write beat hardware set");
endmodule

// ===== sim/rssu_src_model.sv
`timescale 1ns/1ps
module rssu_src_model (
  // Bench requests
  input  wire logic [5:0] lvl_req,
  input  wire logic [3:0] ev_req,
  // Levels toward the block
  output logic            power_on_src,
  output logic            brownout_src,
  output logic            master_clear_pin_n,
  output logic            config_mismatch_src,
  output logic            trap_conflict_src,
  output logic            illegal_cond_src,
  // One-cycle events
  output logic            soft_reset_req,
  output logic            watchdog_timeout,
  output logic            sleep_entered,
  output logic            idle_entered
);
  // Levels stay up for as long as the bench holds them
  assign {illegal_cond_src, trap_conflict_src, config_mismatch_src} =
    lvl_req[5:3];
  assign {brownout_src, power_on_src} = lvl_req[1:0];
  // Pin is active low
  assign master_clear_pin_n = ~lvl_req[2];
  assign {idle_entered, sleep_entered, watchdog_timeout, soft_reset_req} =
    ev_req;
endmodule

// ===== sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import rssu_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic [3:0]  pstrb = 4'hF, ev = '0;
  logic [5:0]  lvl = '0;
  logic        pready, pslverr, err, lowp = 0, fuse = 0;
  logic        pon, bro, mcn, cfg, trp, ill, soft_reset_flag, wdt, slp, idl;
  logic        rst_out, wd_run, reg_keep, wake;
  int          error_cnt = 0, n_compared = 0, cyc = 0;
  rssu_word_t  rd;

  rssu_top u_rssu_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .power_on_src(pon), .brownout_src(bro), .master_clear_pin_n(mcn),
    .config_mismatch_src(cfg), .trap_conflict_src(trp),
    .illegal_cond_src(ill), .soft_reset_req(soft_reset_flag), .watchdog_timeout(wdt),
    .sleep_entered(slp), .idle_entered(idl), .in_low_power(lowp),
    .watchdog_fuse_enable(fuse), .system_reset_out(rst_out),
    .watchdog_run(wd_run), .regulator_sleep_keep(reg_keep),
    .wake_request(wake));
  rssu_src_model u_rssu_src_model (.lvl_req(lvl), .ev_req(ev),
    .power_on_src(pon), .brownout_src(bro), .master_clear_pin_n(mcn),
    .config_mismatch_src(cfg), .trap_conflict_src(trp),
    .illegal_cond_src(ill), .soft_reset_req(soft_reset_flag), .watchdog_timeout(wdt),
    .sleep_entered(slp), .idle_entered(idl));

  initial forever #2 pclk = ~pclk;

  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata[15:0];
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask

  task automatic t_regs();
    apb(0, 0, 0);
    chk("por_value", rd, 16'h0003);
    apb(1, 0, 32'hFFFF_FFFF);
    apb(0, 0, 0);
    chk("all_set", rd, 16'hC3FF);
    chk("no_reset", rst_out, 0);
    chk("wd_on", wd_run, 1);
    chk("keep_on", reg_keep, 1);
    apb(1, 12'h004, 0);
    chk("unmapped_err", err, 1);
    apb(0, 0, 0);
    chk("unmapped_kept", rd, 16'hC3FF);
    apb(1, 0, 0);
    chk("wd_off", wd_run, 0);
    chk("keep_off", reg_keep, 0);
    fuse <= 1;
    apb(0, 0, 0);
    chk("wd_fuse", wd_run, 1);
    chk("cleared", rd, 16'h0000);
    fuse <= 0;
  endtask

  task automatic t_levels();
    int b[6] = '{0, 1, 7, 9, 15, 14};
    for (int i = 0; i < 6; i++) begin
      // Power-on case starts with every other flag set
      apb(1, 0, i ? 0 : 32'hC2DE);
      lvl[i] <= 1;
      repeat (5) @(posedge pclk);
      chk("lvl_reset", rst_out, 1);
      // Write lands while the source is still active
      apb(1, 0, i ? 0 : 32'hC2DE);
      repeat (6) @(posedge pclk);
      chk("lvl_held", rst_out, 1);
      lvl[i] <= 0;
      repeat (8) @(posedge pclk);
      chk("lvl_release", rst_out, 0);
      apb(0, 0, 0);
      chk("lvl_flag", rd, 16'h1 << b[i]);
    end
  endtask

  task automatic t_events();
    int b[4] = '{6, 4, 3, 2};
    for (int i = 0; i < 4; i++) begin
      apb(1, 0, 0);
      ev[i] <= 1;
      @(posedge pclk) ev[i] <= 0;
      @(posedge pclk);
      chk("ev_reset", rst_out, i < 2);
      chk("ev_no_wake", wake, 0);
      repeat (8) @(posedge pclk);
      chk("ev_release", rst_out, 0);
      apb(0, 0, 0);
      chk("ev_flag", rd, 16'h1 << b[i]);
    end
    // Time-out while asleep only wakes
    apb(1, 0, 0);
    lowp <= 1;
    ev[1] <= 1;
    @(posedge pclk) ev[1] <= 0;
    @(posedge pclk);
    chk("wake", wake, 1);
    repeat (4) @(posedge pclk);
    chk("wake_pulse", wake, 0);
    chk("no_wd_reset", rst_out, 0);
    lowp <= 0;
    apb(0, 0, 0);
    chk("wake_flag", rd, 16'h0010);
  endtask

  task automatic tally_and_finish();
    $display("errors %0d compared %0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    t_regs();
    t_levels();
    t_events();
    tally_and_finish();
  end

  // Whole run needs well under a thousand cycles
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
endmodule
